// ==== rtl/xbc_pkg.sv ====
`default_nettype none
package xbc_pkg;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [31:0] XBC_BASE_ADDR   = 32'hf000_0500;
  localparam logic [7:0]  OFS_CON         = 8'h10;
  localparam logic [7:0]  OFS_ADDSEL0     = 8'h20;
  localparam logic [7:0]  OFS_BUSCON0     = 8'h60;
  localparam logic [7:0]  OFS_EMUAS       = 8'h80;
  localparam logic [7:0]  OFS_EMUBC       = 8'h84;
  localparam logic [7:0]  OFS_EMUCON      = 8'h88;
  localparam int unsigned XBC_REGIONS     = 4;
  localparam int unsigned XBC_ENTRIES     = XBC_REGIONS + 1;
  localparam logic [2:0]  XBC_EMU_INDEX   = 3'h4;
  localparam logic [3:0]  XBC_MIRROR_SEG  = 4'hb;
  localparam logic [4:0]  XBC_MASK_ORIGIN = 5'h0f;
  localparam int unsigned XBC_TOUT_SHIFT  = 3;

  // ----------------------------------------------------------------
  // Register layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [8:0] rsv_hi;
    logic [2:0] turnaround_select_change;
    logic       rsv_mid;
    logic [2:0] turnaround_dir_change;
    logic [7:0] bus_idle_timeout;
    logic [1:0] arbitration_role;
    logic       arb_input_async;
    logic       bus_lock_after_grant;
    logic       ext_master_access_en;
    logic       ext_privilege_select;
    logic       ext_addr_reconfig_en;
    logic       rsv_lo;
  } xbc_con_t;

  typedef struct packed {
    logic [19:0] base;
    logic [3:0]  rsv_hi;
    logic [3:0]  mask;
    logic [1:0]  rsv_lo;
    logic        region_mirror_en;
    logic        region_enable;
  } xbc_addsel_t;

  typedef struct packed {
    logic       region_write_block;
    logic [1:0] latch_extra_cycles;
    logic [1:0] byte_ctrl_timing;
    logic       rsv;
    logic [1:0] addr_mux_mode;
    logic [1:0] read_cycle_scale;
    logic [1:0] wait_mode;
    logic       wait_polarity;
    logic       setup_cycle;
    logic [1:0] device_width;
    logic [6:0] read_wait_states;
    logic [2:0] write_wait_states;
    logic [1:0] hold_cycles;
    logic [1:0] recovery_cycles;
    logic [1:0] cycle_scale;
  } xbc_buscon_t;

  typedef enum logic [1:0] {
    ROLE_OFF    = 2'b00,
    ROLE_MASTER = 2'b01,
    ROLE_SLAVE  = 2'b10,
    ROLE_SOLE   = 2'b11
  } xbc_role_t;

  // Decoded access parameters handed to the bus sequencer
  typedef struct packed {
    logic       hit;
    logic [2:0] region;
    logic       write_blocked;
    logic       overlay_select_out;
    logic       mirrored;
    logic [1:0] device_width;
    logic       setup_cycle;
    logic [1:0] wait_mode;
    logic       wait_polarity;
    logic [1:0] addr_mux_mode;
    logic [1:0] byte_ctrl_timing;
    logic [1:0] latch_extra_cycles;
    logic [9:0] read_wait;
    logic [6:0] write_wait;
    logic [5:0] hold;
    logic [5:0] recovery;
    logic [2:0] turnaround;
  } xbc_acc_t;

  // ----------------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_CON     = 32'h0000_0028;
  localparam logic [31:0] RST_ADDSEL  = 32'h0000_0000;
  localparam logic [31:0] RST_BUSCON  = 32'he802_61ff;
  localparam logic [31:0] RST_EMUAS   = 32'hbe00_0031;
  localparam logic [31:0] RST_EMUBC   = 32'h0016_0280;
  localparam logic [3:0]  RST_EMUCON  = 4'h0;
  localparam logic [31:0] WMASK_CON    = 32'h0077_fffe;
  localparam logic [31:0] WMASK_ADDSEL = 32'hffff_f0f3;
  localparam logic [31:0] WMASK_EMUAS  = 32'hffff_f0f2;
  localparam logic [31:0] WMASK_BUSCON = 32'hfbff_ffff;

endpackage
`default_nettype wire

// ==== rtl/xbc_regs.sv ====
`default_nettype none
module xbc_regs
  import xbc_pkg::*;
#(
  parameter logic [31:0] P_BASE_ADDR = XBC_BASE_ADDR
) (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_reg_sel,
  input  wire logic        i_reg_wr,
  input  wire logic [31:0] i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  output logic      [31:0] o_reg_rdata,
  output logic             o_reg_hit,
  input  wire logic        i_arb_req,
  input  wire logic        i_privilege_pin,
  input  wire logic        i_bus_owned,
  input  wire logic        i_bus_active,
  input  wire logic        i_ext_req,
  output logic             o_arb_req_eval,
  output logic             o_ext_supervisor,
  output logic             o_ext_pass,
  output logic             o_bus_lock,
  output logic             o_timeout,
  output logic             o_ext_addr_reconfig_en,
  output xbc_role_t        o_arb_role,
  input  wire logic        i_acc_valid,
  input  wire logic        i_acc_write,
  input  wire logic [31:0] i_acc_addr,
  output logic             o_acc_valid,
  output xbc_acc_t         o_acc
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  xbc_con_t    con_q;
  xbc_addsel_t addsel_q [XBC_ENTRIES];
  xbc_buscon_t buscon_q [XBC_ENTRIES];
  logic [3:0]  emucon_q;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire logic       in_range   = i_reg_addr[31:8] == P_BASE_ADDR[31:8];
  wire logic [7:0] off        = i_reg_addr[7:0];
  wire logic [1:0] idx        = off[3:2];
  wire logic       hit_con    = off == OFS_CON;
  wire logic       hit_addsel = off[7:4] == OFS_ADDSEL0[7:4];
  wire logic       hit_buscon = off[7:4] == OFS_BUSCON0[7:4];
  wire logic       hit_emuas  = off == OFS_EMUAS;
  wire logic       hit_emubc  = off == OFS_EMUBC;
  wire logic       hit_emucon = off == OFS_EMUCON;
  wire logic       mapped     = in_range & (hit_con | hit_addsel |
                                hit_buscon | hit_emuas | hit_emubc |
                                hit_emucon);
  wire logic       wr_en      = i_reg_sel & i_reg_wr & mapped;
  wire logic       rd_en      = i_reg_sel & ~i_reg_wr & in_range;
  wire logic [31:0] wr_con    = i_reg_wdata & WMASK_CON;
  wire logic [31:0] wr_addsel = i_reg_wdata & WMASK_ADDSEL;
  wire logic [31:0] wr_emuas  = (i_reg_wdata & WMASK_EMUAS) |
                                (RST_EMUAS & ~WMASK_EMUAS);
  wire logic [31:0] wr_buscon = i_reg_wdata & WMASK_BUSCON;

  wire logic [31:0] rd_word =
      hit_con    ? con_q :
      hit_addsel ? addsel_q[idx] :
      hit_buscon ? buscon_q[idx] :
      hit_emuas  ? addsel_q[XBC_EMU_INDEX] :
      hit_emubc  ? buscon_q[XBC_EMU_INDEX] :
      hit_emucon ? {28'h0000000, emucon_q} : 32'h0000_0000;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      con_q    <= RST_CON;
      emucon_q <= RST_EMUCON;
    end else if (wr_en) begin
      if (hit_con) con_q <= wr_con;
      if (hit_emucon) emucon_q <= i_reg_wdata[3:0];
    end
  end

  // One process per entry, so no storage word has two writers
  for (genvar g = 0; g < XBC_ENTRIES; g++) begin : g_reg
    localparam bit IS_EMU = g == int'(XBC_EMU_INDEX);
    wire logic sel   = wr_en & (idx == 2'(g));
    wire logic as_we = IS_EMU ? wr_en & hit_emuas : sel & hit_addsel;
    wire logic bc_we = IS_EMU ? wr_en & hit_emubc : sel & hit_buscon;
    always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
        addsel_q[g] <= IS_EMU ? RST_EMUAS : RST_ADDSEL;
        buscon_q[g] <= IS_EMU ? RST_EMUBC : RST_BUSCON;
      end else begin
        if (as_we) addsel_q[g] <= IS_EMU ? wr_emuas : wr_addsel;
        if (bc_we) buscon_q[g] <= wr_buscon;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 32'h0000_0000;
      o_reg_hit   <= 1'b0;
    end else begin
      o_reg_rdata <= rd_en ? rd_word : 32'h0000_0000;
      o_reg_hit   <= i_reg_sel & mapped;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Third stage must agree with second before a change is accepted
  logic [2:0] arb_sync_q;
  logic [2:0] priv_sync_q;
  logic       arb_filt_q;
  logic       priv_filt_q;
  logic       arb_direct_q;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      arb_sync_q   <= 3'h0;
      priv_sync_q  <= 3'h0;
      arb_filt_q   <= 1'b0;
      priv_filt_q  <= 1'b0;
      arb_direct_q <= 1'b0;
    end else begin
      arb_sync_q   <= {arb_sync_q[1:0], i_arb_req};
      priv_sync_q  <= {priv_sync_q[1:0], i_privilege_pin};
      arb_direct_q <= i_arb_req;
      if (arb_sync_q[1] == arb_sync_q[2]) arb_filt_q <= arb_sync_q[2];
      if (priv_sync_q[1] == priv_sync_q[2])
        priv_filt_q <= priv_sync_q[2];
    end
  end

  // ----------------------------------------------------------------
  // Global arbitration controls
  // ----------------------------------------------------------------
  wire logic [10:0] tout_limit =
      11'(con_q.bus_idle_timeout) << XBC_TOUT_SHIFT;
  logic [10:0] idle_cnt_q;
  wire logic   idle = i_bus_owned & ~i_bus_active;
  wire logic   cnt_sat = idle_cnt_q >= tout_limit;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      idle_cnt_q       <= 11'h000;
      o_timeout        <= 1'b0;
      o_arb_req_eval   <= 1'b0;
      o_ext_supervisor <= 1'b0;
      o_ext_pass       <= 1'b0;
      o_bus_lock       <= 1'b0;
    end else begin
      // Counter saturates so a long idle owner keeps the flag up
      idle_cnt_q <= !idle ? 11'h000 :
                    cnt_sat ? idle_cnt_q : idle_cnt_q + 11'h001;
      o_timeout  <= idle & cnt_sat;
      o_arb_req_eval <= con_q.arb_input_async ? arb_filt_q
                                               : arb_direct_q;
      o_ext_supervisor <= con_q.ext_privilege_select & priv_filt_q;
      o_ext_pass <= i_ext_req & con_q.ext_master_access_en;
      o_bus_lock <= i_bus_owned & con_q.bus_lock_after_grant;
    end
  end

  assign o_ext_addr_reconfig_en = con_q.ext_addr_reconfig_en;
  assign o_arb_role = xbc_role_t'(con_q.arbitration_role);

  // ----------------------------------------------------------------
  // Region decode
  // ----------------------------------------------------------------
  logic [XBC_ENTRIES-1:0] hit_vec;
  logic [XBC_ENTRIES-1:0] mir_vec;
  wire logic seg_mirror = i_acc_addr[31:28] == XBC_MIRROR_SEG;

  for (genvar e = 0; e < XBC_ENTRIES; e++) begin : g_dec
    xbc_addsel_t as;
    assign as = addsel_q[e];
    wire logic [19:0] care =
        20'hfffff << (XBC_MASK_ORIGIN - {1'b0, as.mask});
    wire logic [19:0] mir_addr = {as.base[19:16], i_acc_addr[27:12]};
    wire logic dir_m = ((i_acc_addr[31:12] ^ as.base) & care) == 20'h0;
    wire logic mir_m = as.region_mirror_en & seg_mirror &
                       (((mir_addr ^ as.base) & care) == 20'h0);
    assign hit_vec[e] = as.region_enable & (dir_m | mir_m);
    assign mir_vec[e] = as.region_enable & ~dir_m & mir_m;
  end

  logic [2:0] sel_idx;
  always_comb begin
    sel_idx = 3'h0;
    for (int k = XBC_ENTRIES - 1; k >= 0; k--) begin
      if (hit_vec[k]) sel_idx = 3'(k);
    end
  end

  wire logic        any_hit = |hit_vec;
  wire xbc_buscon_t sb      = buscon_q[sel_idx];
  wire logic [2:0]  ws_sh   = (sb.cycle_scale == 2'b00) ? 3'h0 :
                              {1'b0, sb.cycle_scale} + 3'h1;
  wire logic [9:0]  rd_wait =
      10'({3'h0, sb.read_wait_states} << sb.read_cycle_scale);
  wire logic [6:0]  wr_wait =
      7'({4'h0, sb.write_wait_states} << ws_sh);
  wire logic [5:0]  hold_c  =
      6'({4'h0, sb.hold_cycles} << ws_sh);
  wire logic [5:0]  recov_c =
      6'({4'h0, sb.recovery_cycles} << ws_sh);
  wire logic        ovl     = (sel_idx != XBC_EMU_INDEX) &
                              emucon_q[sel_idx[1:0]];

  // ----------------------------------------------------------------
  // Turn-around tracking
  // ----------------------------------------------------------------
  logic       last_hit_q;
  logic [2:0] last_idx_q;
  logic       last_wr_q;
  wire logic cs_change  = last_hit_q & (last_idx_q != sel_idx);
  wire logic dir_change = last_hit_q & (last_idx_q == sel_idx) &
                          (last_wr_q != i_acc_write);
  wire logic [2:0] ta =
      cs_change  ? con_q.turnaround_select_change :
      dir_change ? con_q.turnaround_dir_change : 3'h0;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      last_hit_q  <= 1'b0;
      last_idx_q  <= 3'h0;
      last_wr_q   <= 1'b0;
      o_acc_valid <= 1'b0;
      o_acc       <= '0;
    end else begin
      o_acc_valid <= i_acc_valid;
      if (i_acc_valid && any_hit) begin
        last_hit_q <= 1'b1;
        last_idx_q <= sel_idx;
        last_wr_q  <= i_acc_write;
      end
      if (i_acc_valid) begin
        o_acc.hit                <= any_hit;
        o_acc.region             <= sel_idx;
        o_acc.write_blocked      <= any_hit & i_acc_write &
                                    sb.region_write_block;
        o_acc.overlay_select_out <= any_hit & ovl;
        o_acc.mirrored           <= mir_vec[sel_idx];
        o_acc.device_width       <= sb.device_width;
        o_acc.setup_cycle        <= sb.setup_cycle;
        o_acc.wait_mode          <= sb.wait_mode;
        o_acc.wait_polarity      <= sb.wait_polarity;
        o_acc.addr_mux_mode      <= sb.addr_mux_mode;
        o_acc.byte_ctrl_timing   <= sb.byte_ctrl_timing;
        o_acc.latch_extra_cycles <= sb.latch_extra_cycles;
        o_acc.read_wait          <= rd_wait;
        o_acc.write_wait         <= wr_wait;
        o_acc.hold               <= hold_c;
        o_acc.recovery           <= recov_c;
        o_acc.turnaround         <= any_hit ? ta : 3'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  property p_reconfig_write;
    i_reg_sel && i_reg_wr && in_range && hit_con
      |=> o_ext_addr_reconfig_en == $past(i_reg_wdata[1]);
  endproperty
  a_reconfig_write: assert property (p_reconfig_write)
    else $error("reconfig enable did not follow write");

  property p_priv;
    o_ext_supervisor |-> $past(con_q.ext_privilege_select);
  endproperty
  a_priv: assert property (p_priv)
    else $error("supervisor without privilege select");

  property p_ext_block;
    i_ext_req && !con_q.ext_master_access_en |=> !o_ext_pass;
  endproperty
  a_ext_block: assert property (p_ext_block)
    else $error("external access passed while disabled");

  property p_lock;
    i_bus_owned && con_q.bus_lock_after_grant |=> o_bus_lock;
  endproperty
  a_lock: assert property (p_lock)
    else $error("bus not locked after ownership");

  property p_timeout;
    $rose(o_timeout) |-> $past(idle_cnt_q) >= $past(tout_limit);
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("time-out before idle limit");

  property p_cs_turn;
    i_acc_valid && any_hit && cs_change
      |=> o_acc.turnaround == $past(con_q.turnaround_select_change);
  endproperty
  a_cs_turn: assert property (p_cs_turn)
    else $error("chip select turn-around wrong");

  property p_wr_block;
    i_acc_valid && i_acc_write && any_hit && sb.region_write_block
      |=> o_acc_valid && o_acc.write_blocked;
  endproperty
  a_wr_block: assert property (p_wr_block)
    else $error("write to protected region not blocked");

  property p_lowest;
    i_acc_valid && hit_vec[0] |=> o_acc.hit && o_acc.region == 3'h0;
  endproperty
  a_lowest: assert property (p_lowest)
    else $error("lower region not preferred");

  property p_overlay;
    o_acc.overlay_select_out |-> o_acc.region != XBC_EMU_INDEX;
  endproperty
  a_overlay: assert property (p_overlay)
    else $error("overlay on emulator region");

  // Sync mode: the pin reaches the output one edge after it is sampled
  property p_sync_pin;
    !con_q.arb_input_async |=> o_arb_req_eval == $past(i_arb_req, 2);
  endproperty
  a_sync_pin: assert property (p_sync_pin)
    else $error("sync arbitration input not sampled directly");

  property p_mirror_seg;
    i_acc_valid && i_acc_addr[31:28] != XBC_MIRROR_SEG
      |=> !o_acc.mirrored;
  endproperty
  a_mirror_seg: assert property (p_mirror_seg)
    else $error("mirror hit outside the mirror segment");

  c_timeout: cover property ($rose(o_timeout));
  c_mirror:  cover property (o_acc_valid && o_acc.mirrored);
  c_multi:   cover property (i_acc_valid && $countones(hit_vec) > 1);
  c_block:   cover property (o_acc_valid && o_acc.write_blocked);
  c_turn:    cover property (o_acc_valid && o_acc.turnaround != 3'h0);

endmodule // xbc_regs
`default_nettype wire

// ==== verif/xbc_ext_bus_model.sv ====
`default_nettype none
module xbc_ext_bus_model (
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_grant,
  input  wire logic [7:0] i_busy,
  output logic            o_bus_owned,
  output logic            o_bus_active
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // External bus owner side
  // ----------------------------------------------------------------
  // Ownership follows the grant. The bus then carries a burst of set
  // length and falls idle, so the idle counter sees a real gap
  logic [7:0] left_q;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !i_grant) begin
      o_bus_owned  <= 1'b0;
      o_bus_active <= 1'b0;
      left_q       <= i_busy;
    end else begin
      o_bus_owned  <= 1'b1;
      o_bus_active <= (left_q != 8'h00);
      if (left_q != 8'h00) begin
        left_q <= left_q - 8'h01;
      end
    end
  end
endmodule // xbc_ext_bus_model
`default_nettype wire

// ==== verif/external_bus_config_regs_tb_top.sv ====
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
  $display("wrong value at %0t: got %h want %h", $time, (a), (b)); end end
module external_bus_config_regs_tb_top
  import xbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ofs; logic [31:0] rst; logic [31:0] ones; logic hit;
  } xbc_rrow_t;
  typedef struct packed {
    logic [31:0] a; logic w; logic hit; logic [2:0] rg; logic [2:0] ta;
    logic mir; logic ovl; logic wb;
  } xbc_drow_t;

  logic        clk = 1'b0, rst = 1'b1, sel = 1'b0, wr = 1'b0;
  logic        arb = 1'b0, priv = 1'b0, ext = 1'b0, grant = 1'b0;
  logic        av = 1'b0, aw = 1'b0;
  logic [31:0] addr = 32'h0, wd = 32'h0, aa = 32'h0, rdata, rd;
  logic [7:0]  busy = 8'h00;
  logic        reg_hit, arb_eval, sup, pass, lock, tout, recon;
  logic        owned, active, acc_v, hit;
  xbc_role_t   role;
  xbc_acc_t    acc;
  int          n_errors = 0, cmp_count = 0, n;

  // Unmapped offsets read zero and never answer
  xbc_rrow_t rrows [15] = '{
    '{8'h10, 32'h0000_0028, 32'h0077_fffe, 1'h1},
    '{8'h20, 32'h0000_0000, 32'hffff_f0f3, 1'h1},
    '{8'h24, 32'h0000_0000, 32'hffff_f0f3, 1'h1},
    '{8'h28, 32'h0000_0000, 32'hffff_f0f3, 1'h1},
    '{8'h2c, 32'h0000_0000, 32'hffff_f0f3, 1'h1},
    '{8'h60, 32'he802_61ff, 32'hfbff_ffff, 1'h1},
    '{8'h64, 32'he802_61ff, 32'hfbff_ffff, 1'h1},
    '{8'h68, 32'he802_61ff, 32'hfbff_ffff, 1'h1},
    '{8'h6c, 32'he802_61ff, 32'hfbff_ffff, 1'h1},
    '{8'h80, 32'hbe00_0031, 32'hffff_f0f3, 1'h1},
    '{8'h84, 32'h0016_0280, 32'hfbff_ffff, 1'h1},
    '{8'h88, 32'h0000_0000, 32'h0000_000f, 1'h1},
    '{8'h00, 32'h0000_0000, 32'h0000_0000, 1'h0},
    '{8'h30, 32'h0000_0000, 32'h0000_0000, 1'h0},
    '{8'h90, 32'h0000_0000, 32'h0000_0000, 1'h0}};

  xbc_drow_t drows [8] = '{
    '{32'ha000_0010, 1'h0, 1'h1, 3'h0, 3'h0, 1'h0, 1'h0, 1'h0},
    '{32'ha000_0020, 1'h1, 1'h1, 3'h0, 3'h3, 1'h0, 1'h0, 1'h1},
    '{32'ha800_0000, 1'h1, 1'h1, 3'h1, 3'h5, 1'h0, 1'h1, 1'h0},
    '{32'hb800_0004, 1'h0, 1'h1, 3'h1, 3'h3, 1'h1, 1'h1, 1'h0},
    '{32'hac00_0000, 1'h0, 1'h0, 3'h0, 3'h0, 1'h0, 1'h0, 1'h0},
    '{32'hbe00_1000, 1'h0, 1'h1, 3'h4, 3'h5, 1'h0, 1'h0, 1'h0},
    '{32'ha400_0000, 1'h1, 1'h1, 3'h0, 3'h5, 1'h0, 1'h0, 1'h1},
    '{32'hb000_0000, 1'h1, 1'h0, 3'h0, 3'h0, 1'h0, 1'h0, 1'h0}};

  initial begin
    forever #12.5 clk = ~clk;
  end

  xbc_regs xbc_regs_i (
    .i_clk(clk), .i_sys_rst(rst), .i_reg_sel(sel), .i_reg_wr(wr),
    .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rdata),
    .o_reg_hit(reg_hit), .i_arb_req(arb), .i_privilege_pin(priv),
    .i_bus_owned(owned), .i_bus_active(active), .i_ext_req(ext),
    .o_arb_req_eval(arb_eval), .o_ext_supervisor(sup), .o_ext_pass(pass),
    .o_bus_lock(lock), .o_timeout(tout), .o_ext_addr_reconfig_en(recon),
    .o_arb_role(role), .i_acc_valid(av), .i_acc_write(aw),
    .i_acc_addr(aa), .o_acc_valid(acc_v), .o_acc(acc));

  xbc_ext_bus_model xbc_ext_bus_model_i (
    .i_clk(clk), .i_sys_rst(rst), .i_grant(grant), .i_busy(busy),
    .o_bus_owned(owned), .o_bus_active(active));

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic reg_acc(input logic w, input logic [7:0] ofs,
                         input logic [31:0] d);
    cyc(1);
    sel = 1'b1;
    wr = w;
    addr = XBC_BASE_ADDR + {24'h0, ofs};
    wd = d;
    cyc(1);
    sel = 1'b0;
    rd = rdata;
    hit = reg_hit;
  endtask

  task automatic acc_req(input logic [31:0] a, input logic w);
    cyc(1);
    av = 1'b1;
    aa = a;
    aw = w;
    cyc(1);
    av = 1'b0;
    `CHK(acc_v, 1'b1)
  endtask

  task automatic test_done;
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(6);
    rst = 1'b0;
    foreach (rrows[i]) begin
      reg_acc(1'b0, rrows[i].ofs, 32'h0);
      `CHK(rd, rrows[i].rst)
      `CHK(hit, rrows[i].hit)
      reg_acc(1'b1, rrows[i].ofs, 32'hffff_ffff);
      reg_acc(1'b0, rrows[i].ofs, 32'h0);
      `CHK(rd, rrows[i].ones)
    end
    cyc(1);
    `CHK(rdata, 32'h0)
    for (int k = 0; k < 4; k++) begin
      reg_acc(1'b1, OFS_CON, 32'h0000_0200 | (k << 6));
      `CHK(role, k[1:0])
    end
    // Sync sampling must beat the synchroniser chain by a cycle or more
    reg_acc(1'b1, OFS_CON, 32'h0000_0008);
    arb = 1'b1;
    cyc(2);
    `CHK(arb_eval, 1'b1)
    arb = 1'b0;
    reg_acc(1'b1, OFS_CON, 32'h0000_0028);
    cyc(8);
    arb = 1'b1;
    cyc(2);
    `CHK(arb_eval, 1'b0)
    cyc(8);
    `CHK(arb_eval, 1'b1)
    reg_acc(1'b1, OFS_CON, 32'h0053_0260);
    ext = 1'b1;
    priv = 1'b1;
    grant = 1'b1;
    cyc(6);
    `CHK(pass, 1'b0)
    `CHK(sup, 1'b0)
    `CHK(lock, 1'b0)
    `CHK(recon, 1'b0)
    grant = 1'b0;
    // Burst length is loaded by the model while reset is up or the grant is low
    busy = 8'h04;
    reg_acc(1'b1, OFS_CON, 32'h0053_027e);
    cyc(6);
    `CHK(pass, 1'b1)
    `CHK(sup, 1'b1)
    `CHK(recon, 1'b1)
    // Four busy cycles, then sixteen idle ones before the time-out
    grant = 1'b1;
    n = 0;
    while (tout !== 1'b1) begin
      cyc(1);
      n++;
      if (n > 100) begin
        n_errors++;
        test_done();
      end
    end
    `CHK(n >= 20 && n <= 23, 1'b1)
    `CHK(lock, 1'b1)
    grant = 1'b0;
    reg_acc(1'b1, 8'h20, 32'ha000_0001);
    reg_acc(1'b1, 8'h24, 32'ha800_0013);
    reg_acc(1'b1, 8'h28, 32'ha000_0001);
    reg_acc(1'b1, 8'h2c, 32'h0000_0000);
    reg_acc(1'b1, 8'h80, 32'hbe00_0030);
    reg_acc(1'b1, 8'h60, 32'hcaed_0ae5);
    reg_acc(1'b1, 8'h64, 32'h0000_0000);
    reg_acc(1'b1, 8'h88, 32'h0000_0002);
    acc_req(32'ha000_0000, 1'b0);
    `CHK(acc.read_wait, 10'h028)
    `CHK(acc.write_wait, 7'h0c)
    `CHK(acc.hold, 6'h08)
    `CHK(acc.recovery, 6'h04)
    `CHK(acc.device_width, 2'h1)
    `CHK(acc.setup_cycle, 1'b1)
    `CHK(acc.wait_mode, 2'h2)
    `CHK(acc.addr_mux_mode, 2'h2)
    `CHK(acc.latch_extra_cycles, 2'h2)
    `CHK(acc.wait_polarity, 1'b1)
    `CHK(acc.byte_ctrl_timing, 2'h1)
    cyc(1);
    `CHK(acc_v, 1'b0)
    foreach (drows[i]) begin
      acc_req(drows[i].a, drows[i].w);
      `CHK(acc.hit, drows[i].hit)
      `CHK(acc.turnaround, drows[i].ta)
      if (drows[i].hit) begin
        `CHK(acc.region, drows[i].rg)
        `CHK(acc.mirrored, drows[i].mir)
        `CHK(acc.overlay_select_out, drows[i].ovl)
      end
      if (drows[i].w) `CHK(acc.write_blocked, drows[i].wb)
    end
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    `CHK(role, ROLE_OFF)
    reg_acc(1'b0, OFS_CON, 32'h0);
    `CHK(rd, 32'h0000_0028)
    reg_acc(1'b0, OFS_BUSCON0, 32'h0);
    `CHK(rd, 32'he802_61ff)
    test_done();
  end
endmodule // external_bus_config_regs_tb_top
`default_nettype wire
